// ===== bafp_pkg.sv
// Shared constants and types for the bulk asynchronous FIFO host port.
package bafp_pkg;

	// Register byte addresses.
	localparam logic [11:0] ADDR_RSVD_LO     = 12'h0fc;
	localparam logic [11:0] ADDR_RSVD_HI     = 12'h100;
	localparam logic [11:0] ADDR_FIFO_SIZE   = 12'h104;
	localparam logic [11:0] ADDR_OCCUPANCY   = 12'h108;
	localparam logic [11:0] ADDR_TX_CONTINUE = 12'h10c;
	localparam logic [11:0] ADDR_TX_LAST     = 12'h110;
	localparam logic [11:0] ADDR_RX_POP      = 12'h114;
	localparam logic [11:0] ADDR_RX_HDR_Q0   = 12'h118;
	localparam logic [11:0] ADDR_RX_HDR_Q1   = 12'h11c;
	localparam logic [11:0] ADDR_RX_HDR_Q2   = 12'h120;
	localparam logic [11:0] ADDR_RX_HDR_Q3   = 12'h124;
	localparam logic [11:0] ADDR_HOST_STATUS = 12'h200;
	localparam logic [11:0] ADDR_INT_STATUS  = 12'h204;
	localparam logic [11:0] ADDR_INT_MASK    = 12'h208;
	localparam logic [11:0] ADDR_CONTROL     = 12'h20c;

	// Field layout; bit 00 of the printed numbering is bit 31 here.
	localparam int SIZE_W       = 10;
	localparam int TX_SIZE_LSB  = 16;
	localparam int RX_SIZE_LSB  = 0;
	localparam int OCC_W        = 12;
	localparam int TX_FREE_LSB  = 16;
	localparam int RX_WAIT_LSB  = 0;
	localparam int UNIT_SHIFT   = 2;
	localparam int ERR_W        = 4;
	localparam int CTRL_SOFT_RST = 0;

	// Reset values and error codes.
	localparam logic [SIZE_W-1:0] SIZE_RESET  = 10'h000;
	localparam logic [31:0]       QUAD_RESET  = 32'h0000_0000;
	localparam logic [ERR_W-1:0]  ERR_NONE    = 4'h0;
	localparam logic [ERR_W-1:0]  ERR_RX_EMPTY  = 4'h1;
	localparam logic [ERR_W-1:0]  ERR_RX_PAUSED = 4'h2;
	localparam logic [ERR_W-1:0]  ERR_TX_FULL   = 4'h3;

	// Interrupt bit positions.
	localparam int INT_HDR    = 0;
	localparam int INT_ERR    = 1;
	localparam int INT_TXSENT = 2;
	localparam int INT_W      = 3;

	// Header capture.
	localparam int          HDR_QUADS = 4;
	localparam logic [1:0]  HDR_LAST_IDX = 2'h3;

	typedef enum logic [0:0] {
		APB_IDLE,
		APB_RESP
	} bafp_apb_type;

endpackage : bafp_pkg

// ===== bafp_ram.sv
// Simple dual-port memory with registered read data.
`timescale 1ns/1ns
`default_nettype none
module bafp_ram #(
	parameter int W  = 32,
	parameter int AW = 12
) (
	// Clock.
	input  wire logic          sys_clk,
	// Write side.
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// Read side.
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);

	logic [W-1:0] mem [0:(1<<AW)-1];

	// Read is old data on a same-address collision; the callers wait a cycle or keep a copy when a slot is written on the same edge.
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule : bafp_ram
`default_nettype wire

// ===== bafp_irq.sv
// Sticky interrupt status with write-one-to-clear, mask and level output.
`timescale 1ns/1ns
`default_nettype none
module bafp_irq #(
	parameter int N = 3
) (
	// Clock and reset.
	input  wire logic         sys_clk,
	input  wire logic         srst,
	// Events.
	input  wire logic [N-1:0] events,
	// Software access.
	input  wire logic         clrWrite,
	input  wire logic         maskWrite,
	input  wire logic [N-1:0] wdata,
	// State.
	output logic      [N-1:0] status,
	output logic      [N-1:0] mask,
	output logic              irq
);

	logic [N-1:0] next_status;

	// A new event in the cycle of its clear keeps the bit set.
	always_comb begin
		next_status = (status & ~(clrWrite ? wdata : '0)) | events;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			status <= '0;
			mask   <= '0;
			irq    <= 1'b0;
		end else begin
			status <= next_status;
			if (maskWrite) begin
				mask <= wdata;
			end
			irq <= |(next_status & (maskWrite ? wdata : mask));
		end
	end

endmodule : bafp_irq
`default_nettype wire

// ===== bafp_host_port.sv
// Host port of the bulk asynchronous transmit and receive FIFOs.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Transmit size field, units of four quadlets.
// - Receive size field, units of four quadlets.
// - Both size fields clear on any reset.
// - Transmit free slots readable, zero after reset.
// - Receive waiting quadlets readable, zero after reset.
// - Continue port pushes non-final transmit quadlets.
// - Last port tags end, releases packet.
// - Each receive read that is neither empty nor paused pops oldest quadlet.
// - Empty read returns last quadlet, no pop.
// - Four header quadlets captured in order.
// - Header registers clear on any reset.
// - Transmit ports take full 32-bit quadlets.
// - Addresses 0FCh to 100h hold nothing.
// - Empty receive read sets error 1h.
// - Paused receive read sets error 2h.
// - Push into full transmit sets error 3h.
module bafp_host_port #(
	parameter int AW = 12
) (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// APB slave.
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Transmit stream to the packet engine.
	output logic      [31:0] txData,
	output logic             txLast,
	output logic             txValid,
	input  wire logic        txReady,
	// Receive stream from the packet engine.
	input  wire logic [31:0] rxData,
	input  wire logic        rxHeader,
	input  wire logic        rxValid,
	output logic             rxReady,
	input  wire logic        rxPaused,
	// Interrupt.
	output logic             irq
);

	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEPTH = CW'(1) << AW;
	localparam logic [CW-1:0] ONE   = CW'(1);
	localparam int            OW    = bafp_pkg::OCC_W;

	typedef struct packed {
		bafp_pkg::bafp_apb_type           phase;
		logic                             pready;
		logic                             pslverr;
		logic [31:0]                      prdata;
		logic [bafp_pkg::SIZE_W-1:0]      txSize;
		logic [bafp_pkg::SIZE_W-1:0]      rxSize;
		logic [bafp_pkg::ERR_W-1:0]       err;
		logic [AW-1:0]                    txWr;
		logic [AW-1:0]                    txRd;
		logic [CW-1:0]                    txCount;
		logic [CW-1:0]                    txPend;
		logic [CW-1:0]                    txCommit;
		logic                             txHold;
		logic                             txValid;
		logic                             txLast;
		logic [31:0]                      txData;
		logic [AW-1:0]                    rxWr;
		logic [AW-1:0]                    rxRd;
		logic [CW-1:0]                    rxCount;
		logic                             rxReady;
		logic [31:0]                      rxLastData;
		logic                             rxFresh;
		logic [31:0]                      rxFreshData;
		logic [1:0]                       hdrIdx;
		logic [2:0][31:0]                 hdrShadow;
		logic [bafp_pkg::HDR_QUADS-1:0][31:0] hdr;
		logic                             softRst;
	} bafp_state_type;

	bafp_state_type cur;
	bafp_state_type next_cur;
	bafp_state_type rstState;

	logic [32:0]               txRamOut;
	logic [31:0]               rxRamOut;
	logic                      txWe;
	logic [32:0]               txWdata;
	logic                      rxWe;
	logic [bafp_pkg::INT_W-1:0] intEvents;
	logic                      intClr;
	logic                      intMaskWr;
	logic [bafp_pkg::INT_W-1:0] intStatus;
	logic [bafp_pkg::INT_W-1:0] intMask;

	// Capacity is clipped to the physical depth so an oversize setting cannot overrun the memory.
	function automatic logic [CW-1:0] fifoCap(input logic [bafp_pkg::SIZE_W-1:0] sz);
		logic [bafp_pkg::SIZE_W+bafp_pkg::UNIT_SHIFT-1:0] quads;
		quads = {sz, {bafp_pkg::UNIT_SHIFT{1'b0}}};
		return (quads > DEPTH) ? DEPTH : CW'(quads);
	endfunction : fifoCap

	always_comb begin
		rstState           = '0;
		rstState.phase     = bafp_pkg::APB_IDLE;
		rstState.txSize    = bafp_pkg::SIZE_RESET;
		rstState.rxSize    = bafp_pkg::SIZE_RESET;
		rstState.err       = bafp_pkg::ERR_NONE;
		rstState.rxLastData = bafp_pkg::QUAD_RESET;
		rstState.hdrShadow = '0;
		for (int i = 0; i < bafp_pkg::HDR_QUADS; i++) begin
			rstState.hdr[i] = bafp_pkg::QUAD_RESET;
		end
	end

	always_comb begin
		logic          access;
		logic          txFull;
		logic          txLoad;
		logic [CW-1:0] txCap;
		logic [CW-1:0] rxCap;
		logic [CW-1:0] txFree;
		logic          rxPush;
		logic          rxPop;
		access    = 1'b0;
		txFull    = 1'b0;
		txLoad    = 1'b0;
		txCap     = fifoCap(cur.txSize);
		rxCap     = fifoCap(cur.rxSize);
		txFree    = (cur.txCount >= txCap) ? '0 : (txCap - cur.txCount);
		rxPush    = 1'b0;
		rxPop     = 1'b0;
		txWe      = 1'b0;
		txWdata   = {1'b0, pwdata};
		rxWe      = 1'b0;
		intEvents = '0;
		intClr    = 1'b0;
		intMaskWr = 1'b0;
		next_cur  = cur;

		// APB access: answer in the second access cycle.
		case (cur.phase)
			bafp_pkg::APB_IDLE: begin
				access = psel && penable;
			end
			bafp_pkg::APB_RESP: begin
				next_cur.phase   = bafp_pkg::APB_IDLE;
				next_cur.pready  = 1'b0;
				next_cur.pslverr = 1'b0;
			end
			default: begin
				next_cur.phase = bafp_pkg::APB_IDLE;
			end
		endcase

		txFull = cur.txCount >= txCap;
		if (access) begin
			next_cur.phase   = bafp_pkg::APB_RESP;
			next_cur.pready  = 1'b1;
			next_cur.pslverr = 1'b0;
			next_cur.prdata  = '0;
			case (paddr)
				bafp_pkg::ADDR_FIFO_SIZE: begin
					if (pwrite) begin
						next_cur.txSize = pwdata[bafp_pkg::TX_SIZE_LSB +: bafp_pkg::SIZE_W];
						next_cur.rxSize = pwdata[bafp_pkg::RX_SIZE_LSB +: bafp_pkg::SIZE_W];
					end else begin
						next_cur.prdata[bafp_pkg::TX_SIZE_LSB +: bafp_pkg::SIZE_W] = cur.txSize;
						next_cur.prdata[bafp_pkg::RX_SIZE_LSB +: bafp_pkg::SIZE_W] = cur.rxSize;
					end
				end
				bafp_pkg::ADDR_OCCUPANCY: begin
					if (!pwrite) begin
						next_cur.prdata[bafp_pkg::TX_FREE_LSB +: bafp_pkg::OCC_W] = OW'(txFree);
						next_cur.prdata[bafp_pkg::RX_WAIT_LSB +: bafp_pkg::OCC_W] = OW'(cur.rxCount);
					end
				end
				bafp_pkg::ADDR_TX_CONTINUE, bafp_pkg::ADDR_TX_LAST: begin
					if (pwrite) begin
						if (txFull) begin
							next_cur.err = bafp_pkg::ERR_TX_FULL;
							intEvents[bafp_pkg::INT_ERR] = 1'b1;
						end else begin
							txWe    = 1'b1;
							txWdata = {paddr == bafp_pkg::ADDR_TX_LAST, pwdata};
							next_cur.txWr = cur.txWr + AW'(1);
							if (paddr == bafp_pkg::ADDR_TX_LAST) begin
								next_cur.txCommit = cur.txCommit + cur.txPend + ONE;
								next_cur.txPend   = '0;
							end else begin
								next_cur.txPend = cur.txPend + ONE;
							end
						end
					end
				end
				bafp_pkg::ADDR_RX_POP: begin
					if (!pwrite) begin
						if (cur.rxCount == '0) begin
							next_cur.prdata = cur.rxLastData;
							next_cur.err    = bafp_pkg::ERR_RX_EMPTY;
							intEvents[bafp_pkg::INT_ERR] = 1'b1;
						end else if (rxPaused) begin
							next_cur.prdata = cur.rxLastData;
							next_cur.err    = bafp_pkg::ERR_RX_PAUSED;
							intEvents[bafp_pkg::INT_ERR] = 1'b1;
						end else begin
							rxPop               = 1'b1;
							next_cur.prdata     = cur.rxFresh ? cur.rxFreshData : rxRamOut;
							next_cur.rxLastData = cur.rxFresh ? cur.rxFreshData : rxRamOut;
							next_cur.rxRd       = cur.rxRd + AW'(1);
						end
					end
				end
				bafp_pkg::ADDR_RX_HDR_Q0: next_cur.prdata = pwrite ? '0 : cur.hdr[0];
				bafp_pkg::ADDR_RX_HDR_Q1: next_cur.prdata = pwrite ? '0 : cur.hdr[1];
				bafp_pkg::ADDR_RX_HDR_Q2: next_cur.prdata = pwrite ? '0 : cur.hdr[2];
				bafp_pkg::ADDR_RX_HDR_Q3: next_cur.prdata = pwrite ? '0 : cur.hdr[3];
				bafp_pkg::ADDR_HOST_STATUS: begin
					if (!pwrite) begin
						next_cur.prdata[bafp_pkg::ERR_W-1:0] = cur.err;
					end
				end
				bafp_pkg::ADDR_INT_STATUS: begin
					if (pwrite) begin
						intClr = 1'b1;
					end else begin
						next_cur.prdata[bafp_pkg::INT_W-1:0] = intStatus;
					end
				end
				bafp_pkg::ADDR_INT_MASK: begin
					if (pwrite) begin
						intMaskWr = 1'b1;
					end else begin
						next_cur.prdata[bafp_pkg::INT_W-1:0] = intMask;
					end
				end
				bafp_pkg::ADDR_CONTROL: begin
					if (pwrite && pwdata[bafp_pkg::CTRL_SOFT_RST]) begin
						next_cur.softRst = 1'b1;
					end
				end
				default: begin
					next_cur.pslverr = 1'b1;
				end
			endcase
		end

		// Transmit drain; a freshly written or just-advanced slot waits one cycle for the memory read.
		txLoad = (cur.txCommit != '0) && !cur.txHold && (!cur.txValid || txReady);
		if (cur.txValid && txReady) begin
			next_cur.txValid = 1'b0;
			intEvents[bafp_pkg::INT_TXSENT] = cur.txLast;
		end
		if (txLoad) begin
			next_cur.txValid  = 1'b1;
			next_cur.txData   = txRamOut[31:0];
			next_cur.txLast   = txRamOut[32];
			next_cur.txRd     = cur.txRd + AW'(1);
			next_cur.txCommit = next_cur.txCommit - ONE;
		end
		next_cur.txHold  = txLoad || txWe;
		next_cur.txCount = cur.txCount + (txWe ? ONE : '0) - (txLoad ? ONE : '0);

		// Receive side: header quadlets go to the header registers, the rest to the memory.
		if (rxValid && cur.rxReady) begin
			if (rxHeader) begin
				if (cur.hdrIdx == bafp_pkg::HDR_LAST_IDX) begin
					next_cur.hdr    = {rxData, cur.hdrShadow};
					next_cur.hdrIdx = '0;
					intEvents[bafp_pkg::INT_HDR] = 1'b1;
				end else begin
					next_cur.hdrShadow[cur.hdrIdx] = rxData;
					next_cur.hdrIdx = cur.hdrIdx + 2'h1;
				end
			end else begin
				rxPush        = 1'b1;
				rxWe          = 1'b1;
				next_cur.rxWr = cur.rxWr + AW'(1);
			end
		end
		// The registered memory read misses a quadlet written into the slot under the read pointer, so keep a copy.
		next_cur.rxFresh     = rxWe && (cur.rxWr == cur.rxRd);
		next_cur.rxFreshData = rxData;
		next_cur.rxCount = cur.rxCount + (rxPush ? ONE : '0) - (rxPop ? ONE : '0);
		next_cur.rxReady = next_cur.rxCount < fifoCap(next_cur.rxSize);

		// Software reset clears everything but lets the pending answer finish.
		if (cur.softRst) begin
			next_cur        = rstState;
			next_cur.pready = cur.pready && (cur.phase == bafp_pkg::APB_IDLE);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cur <= rstState;
		end else begin
			cur <= next_cur;
		end
	end

	bafp_ram #(
		.W  (33),
		.AW (AW)
	) u_txRam (
		.sys_clk (sys_clk),
		.we      (txWe),
		.waddr   (cur.txWr),
		.wdata   (txWdata),
		.raddr   (cur.txRd),
		.rdata   (txRamOut)
	);

	bafp_ram #(
		.W  (32),
		.AW (AW)
	) u_rxRam (
		.sys_clk (sys_clk),
		.we      (rxWe),
		.waddr   (cur.rxWr),
		.wdata   (rxData),
		.raddr   (cur.rxRd),
		.rdata   (rxRamOut)
	);

	bafp_irq #(
		.N (bafp_pkg::INT_W)
	) u_irq (
		.sys_clk   (sys_clk),
		.srst      (srst || cur.softRst),
		.events    (intEvents),
		.clrWrite  (intClr),
		.maskWrite (intMaskWr),
		.wdata     (pwdata[bafp_pkg::INT_W-1:0]),
		.status    (intStatus),
		.mask      (intMask),
		.irq       (irq)
	);

	assign prdata  = cur.prdata;
	assign pready  = cur.pready;
	assign pslverr = cur.pslverr;
	assign txData  = cur.txData;
	assign txLast  = cur.txLast;
	assign txValid = cur.txValid;
	assign rxReady = cur.rxReady;

endmodule : bafp_host_port
`default_nettype wire

// ===== bafp_host_port_notes_end.sv
// Intentionally empty compilation unit.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== bafp_host_port_assertions.sv
// Pin-level checks on the host port.
`timescale 1ns/1ns
`default_nettype none
module bafp_host_port_assertions (
	// Clock and reset.
	input wire logic        sys_clk,
	input wire logic        srst,
	// APB.
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Streams and interrupt.
	input wire logic [31:0] txData,
	input wire logic        txLast,
	input wire logic        txValid,
	input wire logic        txReady,
	input wire logic        rxReady,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	wire rsvd = paddr == bafp_pkg::ADDR_RSVD_LO || paddr == bafp_pkg::ADDR_RSVD_HI;
	wire woPort = paddr == bafp_pkg::ADDR_TX_CONTINUE || paddr == bafp_pkg::ADDR_TX_LAST;
	chk_answer_next: assert property ($rose(penable) && psel |=> pready)
		else $error("no answer one cycle after access");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_reserved_refused: assert property (pready && rsvd |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("reserved address answered");
	chk_size_accepted: assert property (pready && paddr == bafp_pkg::ADDR_FIFO_SIZE |-> !pslverr)
		else $error("size register refused");
	chk_push_write_only: assert property (pready && !pwrite && woPort |-> prdata == 32'h0)
		else $error("push port returned data");
	chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
		else $error("transmit quadlet changed before taken");
	chk_tx_gap: assert property ((txValid && txReady) ##1 (txValid && txReady) |=> !txValid)
		else $error("transmit reload too soon");
	chk_reset_idle: assert property ($fell(srst) |-> !rxReady && !txValid && !irq)
		else $error("outputs active after reset");
	cover property (txValid && txReady && txLast);
	cover property (pready && pslverr);
	cover property ($rose(irq));
endmodule : bafp_host_port_assertions
`default_nettype wire

// ===== bafp_engine_model.sv
// Behavioural packet engine facing the transmit and receive streams.
`timescale 1ns/1ns
`default_nettype none
module bafp_engine_model (
	// Clock.
	input wire logic        sys_clk,
	// Transmit stream.
	input wire logic [31:0] txData,
	input wire logic        txLast,
	input wire logic        txValid,
	output logic            txReady,
	// Receive stream.
	output logic     [31:0] rxData,
	output logic            rxHeader,
	output logic            rxValid,
	input wire logic        rxReady
);
	logic        stall = 1'b0;
	logic [32:0] got[$];
	assign txReady = !stall;
	initial begin
		rxData = 32'h0;
		rxHeader = 1'b0;
		rxValid = 1'b0;
	end
	always @(posedge sys_clk) begin
		if (txValid && txReady) got.push_back({txLast, txData});
	end
	// Idle data is inverted so a stale quadlet can never be mistaken for a fresh one.
	task automatic send(input logic [31:0] d, input logic h);
		@(posedge sys_clk);
		rxValid <= 1'b1;
		rxData <= d;
		rxHeader <= h;
		do @(posedge sys_clk); while (rxReady !== 1'b1);
		rxValid <= 1'b0;
		rxData <= ~d;
		rxHeader <= ~h;
	endtask : send
endmodule : bafp_engine_model
`default_nettype wire

// ===== bafp_host_port_bench.sv
// Self-checking bench for the host port.
`timescale 1ns/1ns
`default_nettype none
module bafp_host_port_bench;
	logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, irq;
	logic        txLast, txValid, txReady, rxHeader, rxValid, rxReady, rxPaused, errv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, txData, rxData, rdv;
	int          failures, samples_checked, cyc;
	bafp_host_port #(.AW(4)) dut_u (.*);
	bafp_engine_model eng (.*);
	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			conclude();
		end
	end
	task automatic conclude;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask : rd
	task automatic testReset;
		rd(bafp_pkg::ADDR_FIFO_SIZE, 32'h0);
		rd(bafp_pkg::ADDR_OCCUPANCY, 32'h0);
		rd(bafp_pkg::ADDR_RX_POP, 32'h0);
		rd(bafp_pkg::ADDR_TX_CONTINUE, 32'h0);
		for (int i = 0; i < 4; i++) rd(bafp_pkg::ADDR_RX_HDR_Q0 + 12'(4 * i), 32'h0);
		apb(1'b0, bafp_pkg::ADDR_RSVD_LO, 32'h0);
		chk(errv, 1'b1);
		apb(1'b1, bafp_pkg::ADDR_RSVD_HI, 32'h5);
		chk(errv, 1'b1);
		$display("reset test done");
	endtask : testReset
	// Four units on the transmit side and two on the receive side; the four give the full 16 slots of the small memory.
	task automatic testTx;
		apb(1'b1, bafp_pkg::ADDR_FIFO_SIZE, 32'h0004_0002);
		rd(bafp_pkg::ADDR_FIFO_SIZE, 32'h0004_0002);
		rd(bafp_pkg::ADDR_OCCUPANCY, 32'h0010_0000);
		eng.stall <= 1'b1;
		apb(1'b1, bafp_pkg::ADDR_TX_CONTINUE, 32'h8000_0001);
		apb(1'b1, bafp_pkg::ADDR_TX_CONTINUE, 32'h0000_0002);
		rd(bafp_pkg::ADDR_OCCUPANCY, 32'h000e_0000);
		apb(1'b1, bafp_pkg::ADDR_TX_LAST, 32'hffff_fffe);
		repeat (8) @(posedge sys_clk);
		eng.stall <= 1'b0;
		for (int i = 0; i < 60 && eng.got.size() < 3; i++) @(posedge sys_clk);
		chk(33'(eng.got.size()), 33'h3);
		chk(eng.got[0], {1'b0, 32'h8000_0001});
		chk(eng.got[1], {1'b0, 32'h0000_0002});
		chk(eng.got[2], {1'b1, 32'hffff_fffe});
		rd(bafp_pkg::ADDR_OCCUPANCY, 32'h0010_0000);
		rd(bafp_pkg::ADDR_INT_STATUS, 32'h6);
		$display("transmit test done");
	endtask : testTx
	task automatic testTxFull;
		for (int i = 0; i < 16; i++) apb(1'b1, bafp_pkg::ADDR_TX_CONTINUE, 32'(i));
		rd(bafp_pkg::ADDR_OCCUPANCY, 32'h0);
		apb(1'b1, bafp_pkg::ADDR_TX_LAST, 32'h1234_5678);
		rd(bafp_pkg::ADDR_HOST_STATUS, 32'h3);
		apb(1'b1, bafp_pkg::ADDR_CONTROL, 32'h1);
		rd(bafp_pkg::ADDR_FIFO_SIZE, 32'h0);
		rd(bafp_pkg::ADDR_OCCUPANCY, 32'h0);
		rd(bafp_pkg::ADDR_HOST_STATUS, 32'h0);
		$display("full test done");
	endtask : testTxFull
	task automatic testRx;
		apb(1'b1, bafp_pkg::ADDR_FIFO_SIZE, 32'h0000_0002);
		for (int i = 0; i < 4; i++) eng.send(32'h8111_0000 + 32'(i), 1'b1);
		for (int i = 0; i < 3; i++) eng.send(32'ha000_0000 + 32'(i), 1'b0);
		for (int i = 0; i < 4; i++) rd(bafp_pkg::ADDR_RX_HDR_Q0 + 12'(4 * i), 32'h8111_0000 + 32'(i));
		rd(bafp_pkg::ADDR_OCCUPANCY, 32'h3);
		for (int i = 0; i < 3; i++) rd(bafp_pkg::ADDR_RX_POP, 32'ha000_0000 + 32'(i));
		rd(bafp_pkg::ADDR_RX_POP, 32'ha000_0002);
		rd(bafp_pkg::ADDR_HOST_STATUS, 32'h1);
		rd(bafp_pkg::ADDR_RX_HDR_Q0, 32'h8111_0000);
		eng.send(32'h5a5a_0004, 1'b0);
		rxPaused <= 1'b1;
		rd(bafp_pkg::ADDR_RX_POP, 32'ha000_0002);
		rd(bafp_pkg::ADDR_HOST_STATUS, 32'h2);
		rxPaused <= 1'b0;
		rd(bafp_pkg::ADDR_RX_POP, 32'h5a5a_0004);
		$display("receive test done");
	endtask : testRx
	task automatic testIrq;
		rd(bafp_pkg::ADDR_INT_STATUS, 32'h3);
		chk(irq, 1'b0);
		apb(1'b1, bafp_pkg::ADDR_INT_MASK, 32'h1);
		@(posedge sys_clk);
		chk(irq, 1'b1);
		apb(1'b1, bafp_pkg::ADDR_INT_STATUS, 32'h1);
		@(posedge sys_clk);
		chk(irq, 1'b0);
		rd(bafp_pkg::ADDR_INT_STATUS, 32'h2);
		$display("interrupt test done");
	endtask : testIrq
	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		rxPaused = 1'b0;
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		testReset();
		testTx();
		testTxFull();
		testRx();
		testIrq();
		conclude();
	end
endmodule : bafp_host_port_bench
bind bafp_host_port bafp_host_port_assertions chk_u (.sys_clk, .srst, .paddr, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .txData, .txLast, .txValid, .txReady, .rxReady, .irq);
`default_nettype wire
